// ---- rtl/tmoc_top.sv ----
// 16-bit timer counter with three output compare channels and APB access
`timescale 1ns/1ps
`include "tmoc_cfg.svh"
// Summary of operation
// - Continuous 16-bit compare per channel
// - Match sets flag next timer tick
// - Enabled flag requests interrupt, ack clears
// - Writing one clears match flag
// - Channel A may define counter TOP
// - Double buffering only in PWM modes
// - Buffer loads active at TOP/BOTTOM
// - CPU reaches buffer or active register
// - Compare high byte read directly
// - High to staging, low loads all
// - Force strobe acts without flag, outside PWM modes
// - Counter write blocks next tick's matches
// - Output bit survives mode change
// - Action bits take effect immediately
// - Reset clears output bits
// - Nonzero action overrides port value
// - Action zero leaves output alone
// - Action bits never alter counting
// - Normal mode wraps 0xffff to 0
// - Overflow flag set at wrap
// - CPU counter write beats counting
module tmoc_top
  import tmoc_pkg::*;
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_TIMER_TICK,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic [2:0]  I_IRQ_ACK_CMP,
  input  wire logic        I_IRQ_ACK_OVF,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic      [2:0]  O_IRQ_CMP,
  output logic             O_IRQ_OVF,
  output logic      [2:0]  O_PIN_OUT,
  output logic      [2:0]  O_PIN_OE
);

  localparam int NCH = `TMOC_CH_NUM;

  // Bus phase decode
  logic             setup_rd;      // Read setup cycle
  logic             acc_wr;        // Write access cycle
  logic [7:0]       wbyte;         // Written data byte
  logic             hit;           // Address is mapped
  logic [31:0]      rdata_d;       // Read mux
  logic [31:0]      rdata_q;       // Read data held for access
  // Timer state
  tmoc_word_t       cnt_q;         // counter_value
  logic [7:0]       temp_q;        // Shared staging byte
  logic             blk_q;         // Match block after counter write
  logic [3:0]       mode_q;        // waveform_mode_select
  tmoc_mode_e       mclass;        // Decoded counting class
  tmoc_word_t       top_v;         // Current TOP
  logic             dbuf;          // Double buffering active
  logic             cnt_wr;        // CPU writes counter low byte
  logic             wrap;          // Counter goes TOP to BOTTOM
  logic             ovf_q;         // overflow_flag
  logic             ovf_en_q;      // Overflow interrupt enable
  tmoc_chan_s [2:0] ch_q;          // Per-channel control
  tmoc_word_t [2:0] ocr_q;         // Active compare_value_reg
  tmoc_word_t [2:0] buf_q;         // Compare buffer registers
  logic [2:0]       flag_q;        // compare_match_flag
  logic [2:0]       oc_q;          // compare_output_bit
  logic [2:0]       match;         // Qualified match this tick
  logic [2:0]       force_p;       // force_compare_strobe pulse
  logic [2:0]       eq;            // Raw comparator outputs

  // Waveform mode to counting class
  function automatic tmoc_mode_e mode_class(input logic [3:0] m);
    case (m)
      4'h0:                      mode_class = TMOC_NORMAL;
      4'h4, 4'hc:                mode_class = TMOC_CTC;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: mode_class = TMOC_PWM_TOP;
      default:                   mode_class = TMOC_PWM_BOT;
    endcase
  endfunction

  assign mclass = mode_class(mode_q);
  assign dbuf   = (mclass == TMOC_PWM_TOP) || (mclass == TMOC_PWM_BOT);

  always_comb begin
    case (mode_q)
      4'h1, 4'h5:               top_v = `TMOC_TOP_8BIT;
      4'h2, 4'h6:               top_v = `TMOC_TOP_9BIT;
      4'h3, 4'h7:               top_v = `TMOC_TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf:   top_v = ocr_q[0];
      default:                  top_v = `TMOC_MAX_VAL;
    endcase
  end

  // Bus phases; writes act in access, read data sampled in setup
  assign setup_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign acc_wr   = I_PSEL && I_PENABLE && I_PWRITE && hit;
  assign wbyte    = I_PWDATA[7:0];
  assign cnt_wr   = acc_wr && (I_PADDR == `TMOC_OFF_CNT_L);
  // Normal mode wraps at MAX; all other modes wrap at TOP only
  assign wrap     = (mclass == TMOC_NORMAL) ? (cnt_q == `TMOC_MAX_VAL)
                  : (cnt_q == top_v);

  // Address decode and read mux
  always_comb begin
    hit     = 1'b1;
    rdata_d = 32'h0000_0000;
    case (I_PADDR)
      `TMOC_OFF_CTRL: begin
        rdata_d = {20'h00000, mode_q, 2'b00, ch_q[2].action,
                   ch_q[1].action, ch_q[0].action};
      end
      `TMOC_OFF_FORCE: rdata_d = 32'h0000_0000;
      `TMOC_OFF_IRQEN: begin
        rdata_d = {28'h0000000, ovf_en_q, ch_q[2].irq_en,
                   ch_q[1].irq_en, ch_q[0].irq_en};
      end
      `TMOC_OFF_FLAGS:  rdata_d = {28'h0000000, ovf_q, flag_q};
      `TMOC_OFF_CNT_L:  rdata_d = {24'h000000, cnt_q[7:0]};
      // High counter byte always comes from staging
      `TMOC_OFF_CNT_H:  rdata_d = {24'h000000, temp_q};
      8'h18: rdata_d = {24'h000000, dbuf ? buf_q[0][7:0] : ocr_q[0][7:0]};
      8'h1c: rdata_d = {24'h000000, dbuf ? buf_q[0][15:8] : ocr_q[0][15:8]};
      8'h20: rdata_d = {24'h000000, dbuf ? buf_q[1][7:0] : ocr_q[1][7:0]};
      8'h24: rdata_d = {24'h000000, dbuf ? buf_q[1][15:8] : ocr_q[1][15:8]};
      8'h28: rdata_d = {24'h000000, dbuf ? buf_q[2][7:0] : ocr_q[2][7:0]};
      8'h2c: rdata_d = {24'h000000, dbuf ? buf_q[2][15:8] : ocr_q[2][15:8]};
      `TMOC_OFF_PORT: begin
        rdata_d = {25'h0000000, ch_q[2].port_dir, ch_q[1].port_dir,
                   ch_q[0].port_dir, 1'b0, ch_q[2].port_val,
                   ch_q[1].port_val, ch_q[0].port_val};
      end
      `TMOC_OFF_STATUS: rdata_d = {29'h00000000, oc_q};
      default: begin
        hit     = 1'b0;
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Zero-wait slave; unmapped access answers with an error
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !hit;
  assign O_PRDATA  = rdata_q;

  // Read data captured in setup so the answer comes from a flop
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup_rd) begin
      rdata_q <= rdata_d;
    end
  end

  // Shared staging byte: high writes fill it, low counter read loads it
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      temp_q <= `TMOC_RST_BYTE;
    end else if (acc_wr && (I_PADDR == `TMOC_OFF_CNT_H ||
                            I_PADDR == 8'h1c || I_PADDR == 8'h24 ||
                            I_PADDR == 8'h2c)) begin
      temp_q <= wbyte;
    end else if (setup_rd && I_PADDR == `TMOC_OFF_CNT_L) begin
      temp_q <= cnt_q[15:8];
    end
  end

  // Control: mode, actions, enables, port bits
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      mode_q   <= 4'h0;
      ovf_en_q <= 1'b0;
      ch_q     <= '0;
    end else if (acc_wr) begin
      case (I_PADDR)
        `TMOC_OFF_CTRL: begin
          mode_q          <= I_PWDATA[`TMOC_CTRL_MODE_LSB +: 4];
          ch_q[0].action  <= I_PWDATA[1:0];
          ch_q[1].action  <= I_PWDATA[3:2];
          ch_q[2].action  <= I_PWDATA[5:4];
        end
        `TMOC_OFF_IRQEN: begin
          ch_q[0].irq_en <= I_PWDATA[0];
          ch_q[1].irq_en <= I_PWDATA[1];
          ch_q[2].irq_en <= I_PWDATA[2];
          ovf_en_q       <= I_PWDATA[`TMOC_FLAG_OVF_BIT];
        end
        `TMOC_OFF_PORT: begin
          ch_q[0].port_val <= I_PWDATA[0];
          ch_q[1].port_val <= I_PWDATA[1];
          ch_q[2].port_val <= I_PWDATA[2];
          ch_q[0].port_dir <= I_PWDATA[`TMOC_PORT_DIR_LSB];
          ch_q[1].port_dir <= I_PWDATA[`TMOC_PORT_DIR_LSB + 1];
          ch_q[2].port_dir <= I_PWDATA[`TMOC_PORT_DIR_LSB + 2];
        end
        default: ;
      endcase
    end
  end

  // Counter; CPU write wins over clear and count
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cnt_q <= `TMOC_RST_WORD;
    end else if (cnt_wr) begin
      cnt_q <= {temp_q, wbyte};
    end else if (I_TIMER_TICK) begin
      if (wrap) begin
        cnt_q <= `TMOC_RST_WORD;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // Match block armed by a counter write, consumed by next tick
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      blk_q <= 1'b0;
    end else if (cnt_wr) begin
      blk_q <= 1'b1;
    end else if (I_TIMER_TICK) begin
      blk_q <= 1'b0;
    end
  end

  // Overflow flag; set wins over software and ack clear
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ovf_q <= 1'b0;
    end else begin
      if (I_TIMER_TICK && !cnt_wr && wrap) begin
        ovf_q <= 1'b1;
      end else if (I_IRQ_ACK_OVF || (acc_wr &&
               I_PADDR == `TMOC_OFF_FLAGS &&
               I_PWDATA[`TMOC_FLAG_OVF_BIT])) begin
        ovf_q <= 1'b0;
      end
    end
  end

  assign O_IRQ_OVF = ovf_q && ovf_en_q;

  // Per-channel compare, flag and waveform logic
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [7:0] off_l;              // Low byte offset of channel
    logic       wr_l;               // Low byte write strobe
    logic       act_nz;             // Channel drives its pin
    assign off_l = `TMOC_OFF_CMP_L0 + 8'(i) * `TMOC_CMP_STRIDE;
    assign wr_l  = acc_wr && (I_PADDR == off_l);
    assign act_nz = |ch_q[i].action;

    assign eq[i]      = (cnt_q == ocr_q[i]);
    assign match[i]   = I_TIMER_TICK && eq[i] && !blk_q;
    assign force_p[i] = acc_wr && (I_PADDR == `TMOC_OFF_FORCE) &&
                        I_PWDATA[i] && !dbuf;

    // Buffer takes CPU writes while buffering is active
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
        buf_q[i] <= `TMOC_RST_WORD;
      end else if (wr_l && dbuf) begin
        buf_q[i] <= {temp_q, wbyte};
      end
    end

    // Active compare: direct write or buffered load
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
        ocr_q[i] <= `TMOC_RST_WORD;
      end else if (wr_l && !dbuf) begin
        ocr_q[i] <= {temp_q, wbyte};
      end else if (dbuf && I_TIMER_TICK && !cnt_wr &&
                   ((mclass == TMOC_PWM_TOP) ? wrap
                    : (cnt_q == `TMOC_RST_WORD))) begin
        ocr_q[i] <= buf_q[i];
      end
    end

    // Match flag; hardware set wins over clear
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
        flag_q[i] <= 1'b0;
      end else if (match[i]) begin
        flag_q[i] <= 1'b1;
      end else if (I_IRQ_ACK_CMP[i] || (acc_wr &&
               I_PADDR == `TMOC_OFF_FLAGS && I_PWDATA[i])) begin
        flag_q[i] <= 1'b0;
      end
    end

    assign O_IRQ_CMP[i] = flag_q[i] && ch_q[i].irq_en;

    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
        oc_q[i] <= 1'b0;
      end else if (!dbuf) begin
        if (match[i] || force_p[i]) begin
          case (ch_q[i].action)
            2'b01:   oc_q[i] <= !oc_q[i];
            2'b10:   oc_q[i] <= 1'b0;
            2'b11:   oc_q[i] <= 1'b1;
            default: oc_q[i] <= oc_q[i];
          endcase
        end
      end else if (I_TIMER_TICK && !cnt_wr && wrap &&
                   ch_q[i].action[1]) begin
        // Period start: non-inverted sets, inverted clears
        oc_q[i] <= !ch_q[i].action[0];
      end else if (match[i] && ch_q[i].action[1]) begin
        oc_q[i] <= ch_q[i].action[0];
      end
    end

    assign O_PIN_OUT[i] = act_nz ? oc_q[i] : ch_q[i].port_val;
    assign O_PIN_OE[i]  = ch_q[i].port_dir;
  end

  // Checks on the channel and counter behaviour
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  a_flag_after_match: assert property (
    match[0] |=> flag_q[0])
    else $error("match flag not set after match");
  a_equal_gives_match: assert property (
    (I_TIMER_TICK && !blk_q && cnt_q == ocr_q[1]) |-> match[1])
    else $error("equal values gave no match");
  a_block_after_write: assert property (
    (cnt_wr ##1 I_TIMER_TICK) |-> match == 3'b000)
    else $error("match not blocked after counter write");
  a_flag_w1c_clear: assert property (
    (acc_wr && I_PADDR == `TMOC_OFF_FLAGS && I_PWDATA[2] && !match[2])
    |=> !flag_q[2])
    else $error("write one did not clear flag");
  a_irq_ack_clear: assert property (
    (flag_q[1] && ch_q[1].irq_en && I_IRQ_ACK_CMP[1] && !match[1])
    |-> O_IRQ_CMP[1] ##1 !flag_q[1])
    else $error("interrupt request or ack clear wrong");
  a_normal_wrap: assert property (
    (mclass == TMOC_NORMAL && I_TIMER_TICK && !cnt_wr &&
     cnt_q == `TMOC_MAX_VAL) |=> (cnt_q == `TMOC_RST_WORD) && ovf_q)
    else $error("normal mode wrap or overflow wrong");
  a_cnt_write_wins: assert property (
    cnt_wr |=> cnt_q == {$past(temp_q), $past(wbyte)})
    else $error("counter write lost to counting");
  a_force_no_flag: assert property (
    (force_p[0] && !match[0] && !flag_q[0]) |=> !flag_q[0])
    else $error("force strobe set the flag");
  a_action_zero_hold: assert property (
    (ch_q[0].action == 2'b00) |=> $stable(oc_q[0]))
    else $error("action zero changed output bit");
  a_toggle_on_match: assert property (
    (!dbuf && match[2] && ch_q[2].action == 2'b01) |=>
    oc_q[2] != $past(oc_q[2]))
    else $error("toggle action did not toggle");
  a_pin_override: assert property (
    (ch_q[1].action != 2'b00) |-> O_PIN_OUT[1] == oc_q[1])
    else $error("pin not overridden by output bit");

  c_flag_set:    cover property (match[0] ##1 flag_q[0]);
  c_cnt_block:   cover property (cnt_wr ##[1:20] (I_TIMER_TICK && eq[0]));
  c_buf_load:    cover property (dbuf && wrap && I_TIMER_TICK);
  c_force_used:  cover property (force_p[0] && ch_q[0].action == 2'b01);

endmodule

// ---- rtl/tmoc_cfg.svh ----
// Register map, field positions, reset values and fixed TOP values
`ifndef TMOC_CFG_SVH
`define TMOC_CFG_SVH
`define TMOC_CH_NUM        3
`define TMOC_OFF_CTRL      8'h00
`define TMOC_OFF_FORCE     8'h04
`define TMOC_OFF_IRQEN     8'h08
`define TMOC_OFF_FLAGS     8'h0c
`define TMOC_OFF_CNT_L     8'h10
`define TMOC_OFF_CNT_H     8'h14
`define TMOC_OFF_CMP_L0    8'h18
`define TMOC_OFF_CMP_H0    8'h1c
`define TMOC_CMP_STRIDE    8'h08
`define TMOC_OFF_PORT      8'h30
`define TMOC_OFF_STATUS    8'h34
`define TMOC_CTRL_MODE_LSB 8
`define TMOC_FLAG_OVF_BIT  3
`define TMOC_PORT_DIR_LSB  4
`define TMOC_RST_BYTE      8'h00
`define TMOC_RST_WORD      16'h0000
`define TMOC_MAX_VAL       16'hffff
`define TMOC_TOP_8BIT      16'h00ff
`define TMOC_TOP_9BIT      16'h01ff
`define TMOC_TOP_10BIT     16'h03ff
`endif

// ---- rtl/tmoc_pkg.sv ----
// Types shared by the timer output compare block
package tmoc_pkg;
  typedef logic [15:0] tmoc_word_t;
  // Counting behaviour class decoded from the waveform mode
  typedef enum logic [1:0] {
    TMOC_NORMAL,
    TMOC_CTC,
    TMOC_PWM_TOP,
    TMOC_PWM_BOT
  } tmoc_mode_e;
  // Per-channel control carried together
  typedef struct packed {
    logic [1:0] action;
    logic       irq_en;
    logic       port_val;
    logic       port_dir;
  } tmoc_chan_s;
endpackage

// ---- sim/tb_timer16_output_compare.sv ----
// Self-checking testbench of the timer output compare block
`timescale 1ns/1ps
`include "tmoc_cfg.svh"
module tb_timer16_output_compare;
  import tmoc_pkg::*;
  logic        clk = 1'h0;      // 40 MHz system clock
  logic        arst_n = 1'h0;   // Reset, active low
  logic        tick = 1'h0;     // Timer clock enable
  logic        psel = 1'h0;     // APB request lines
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  ack_cmp = 3'h0;  // Interrupt serviced pulses
  logic        ack_ovf = 1'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  irq_cmp;
  logic        irq_ovf;
  logic [2:0]  pin_out;
  logic [2:0]  pin_oe;
  int          errors = 0;
  int          n_compared = 0;
  logic [15:0] lfsr = 16'h0051; // Fixed seed keeps runs repeatable
  logic [31:0] q;               // Last read data
  logic        err;             // Last slave error
  logic [15:0] c;               // Random count base
  logic [15:0] v;               // 16-bit read back
  logic [2:0]  st;              // Expected output bits
  logic [2:0]  pv;              // Port values
  logic [2:0]  dv;              // Port directions
  logic [2:0]  m;               // Channel mask
  logic [7:0]  ca;              // Channel compare low address
  int          ch;

  // Free running clock
  always #12.5 clk = ~clk;

  tmoc_top i_dut (
    .I_CLOCK       (clk),
    .I_ARST_N      (arst_n),
    .I_TIMER_TICK  (tick),
    .I_PSEL        (psel),
    .I_PENABLE     (penable),
    .I_PWRITE      (pwrite),
    .I_PADDR       (paddr),
    .I_PWDATA      (pwdata),
    .I_IRQ_ACK_CMP (ack_cmp),
    .I_IRQ_ACK_OVF (ack_ovf),
    .O_PRDATA      (prdata),
    .O_PREADY      (pready),
    .O_PSLVERR     (pslverr),
    .O_IRQ_CMP     (irq_cmp),
    .O_IRQ_OVF     (irq_ovf),
    .O_PIN_OUT     (pin_out),
    .O_PIN_OE      (pin_oe)
  );

  // Next pseudo random value
  function automatic logic [15:0] rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Output bit after a match for an action code
  function automatic logic act(input logic o, input logic [1:0] k);
    case (k)
      2'h1: return ~o;
      2'h2: return 1'h0;
      2'h3: return 1'h1;
      default: return o;
    endcase
  endfunction

  // Verdict and end of run
  task automatic conclude();
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Value comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; setup waits an edge so strobes never re-assert
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 16) begin
      errors++;
      conclude();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask

  // High byte first, low byte loads all 16 bits
  task automatic w16(input logic [7:0] a, input logic [15:0] d);
    apb(1'h1, a + 8'h4, {24'h0, d[15:8]});
    apb(1'h1, a, {24'h0, d[7:0]});
  endtask

  // Low byte first so the high byte is latched
  task automatic r16(input logic [7:0] a, output logic [15:0] r);
    rd(a);
    r[7:0] = q[7:0];
    rd(a + 8'h4);
    r[15:8] = q[7:0];
  endtask

  // Timer ticks of one system cycle each
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'h1;
      @(posedge clk);
      tick <= 1'h0;
    end
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'h1;
    rd(`TMOC_OFF_STATUS);
    chk(16'(q[2:0]), 16'h0);
    chk(16'(pin_out), 16'h0);
    // Unmapped address is refused
    rd(8'h3c);
    chk(16'(err), 16'h1);
    lfsr = rnd(lfsr);
    pv = lfsr[2:0];
    dv = lfsr[5:3];
    apb(1'h1, `TMOC_OFF_PORT, {25'h0, dv, 1'h0, pv});
    apb(1'h1, `TMOC_OFF_IRQEN, 32'hf);
    st = 3'h0;
    // Each code twice, so clear and toggle see a set bit
    for (int k = 0; k < 6; k++) begin
      ch = k % 3;
      m = 3'h1 << ch;
      ca = `TMOC_OFF_CMP_L0 + 8'(ch) * `TMOC_CMP_STRIDE;
      lfsr = rnd(lfsr);
      c = {1'h0, lfsr[14:0]} + 16'h10;
      apb(1'h1, `TMOC_OFF_CTRL, 32'((k + k / 3) % 3 + 1) << (2 * ch));
      w16(ca, c);
      // Stage a different high byte, then read compare directly
      apb(1'h1, `TMOC_OFF_CNT_H, {24'h0, ~c[15:8]});
      r16(ca, v);
      chk(v, c);
      w16(`TMOC_OFF_CNT_L, c);
      tk(1);
      rd(`TMOC_OFF_FLAGS);
      chk(16'(q[2:0]), 16'h0);
      w16(ca, c + 16'h2);
      tk(1);
      rd(`TMOC_OFF_FLAGS);
      chk(16'(q[2:0]), 16'h0);
      tk(1);
      st[ch] = act(st[ch], 2'((k + k / 3) % 3 + 1));
      rd(`TMOC_OFF_FLAGS);
      chk(16'(q[2:0]), 16'(m));
      chk(16'(irq_cmp), 16'(m));
      rd(`TMOC_OFF_STATUS);
      chk(16'(q[2:0]), 16'(st));
      chk(16'(pin_out), 16'((pv & ~m) | (st & m)));
      chk(16'(pin_oe), 16'(dv));
      // Service pulse on one channel, write one on the others
      if (ch == 1) begin
        ack_cmp <= m;
        @(posedge clk);
        ack_cmp <= 3'h0;
      end else begin
        apb(1'h1, `TMOC_OFF_FLAGS, {29'h0, m});
      end
      rd(`TMOC_OFF_FLAGS);
      chk(16'(q[2:0]), 16'h0);
    end
    // Force toggles channel A without a flag
    apb(1'h1, `TMOC_OFF_CTRL, 32'h1);
    apb(1'h1, `TMOC_OFF_FORCE, 32'h1);
    st[0] = ~st[0];
    rd(`TMOC_OFF_STATUS);
    chk(16'(q[2:0]), 16'(st));
    rd(`TMOC_OFF_FLAGS);
    chk(16'(q[2:0]), 16'h0);
    apb(1'h1, `TMOC_OFF_CTRL, 32'h0);
    apb(1'h1, `TMOC_OFF_FORCE, 32'h1);
    rd(`TMOC_OFF_STATUS);
    chk(16'(q[2:0]), 16'(st));
    chk(16'(pin_out), 16'(pv));
    apb(1'h1, `TMOC_OFF_CTRL, 32'h400);
    rd(`TMOC_OFF_STATUS);
    chk(16'(q[2:0]), 16'(st));
    // PWM buffer holds a new B value until the TOP wrap
    apb(1'h1, `TMOC_OFF_CTRL, 32'h0);
    w16(8'h20, 16'h0050);
    apb(1'h1, `TMOC_OFF_CTRL, 32'h508);
    w16(8'h20, 16'h0020);
    w16(`TMOC_OFF_CNT_L, 16'h004e);
    tk(3);
    rd(`TMOC_OFF_FLAGS);
    chk(16'(q[1]), 16'h1);
    apb(1'h1, `TMOC_OFF_FLAGS, 32'hf);
    w16(`TMOC_OFF_CNT_L, 16'h00fd); // never loads TOP
    tk(35);
    rd(`TMOC_OFF_FLAGS);
    chk(16'(q[1]), 16'h0);
    tk(1);
    rd(`TMOC_OFF_FLAGS);
    chk(16'(q[1]), 16'h1);
    // Normal mode wrap and overflow
    apb(1'h1, `TMOC_OFF_CTRL, 32'h0);
    apb(1'h1, `TMOC_OFF_FLAGS, 32'hf);
    w16(`TMOC_OFF_CNT_L, 16'hfffe);
    tk(1);
    rd(`TMOC_OFF_FLAGS);
    chk(16'(q[3]), 16'h0);
    tk(1);
    rd(`TMOC_OFF_FLAGS);
    chk(16'(q[3]), 16'h1);
    chk(16'(irq_ovf), 16'h1);
    r16(`TMOC_OFF_CNT_L, v);
    chk(v, 16'h0);
    ack_ovf <= 1'h1;
    @(posedge clk);
    ack_ovf <= 1'h0;
    rd(`TMOC_OFF_FLAGS);
    chk(16'(q[3]), 16'h0);
    // Counter write while ticking every cycle wins
    lfsr = rnd(lfsr);
    tick <= 1'h1;
    w16(`TMOC_OFF_CNT_L, lfsr);
    // One more tick after the write: it counts but matches nothing
    @(posedge clk);
    tick <= 1'h0;
    r16(`TMOC_OFF_CNT_L, v);
    chk(v, lfsr + 16'h1);
    conclude();
  end
endmodule
